//--- include/drive_prot_consts.svh
// Constants for the drive current protection block
`ifndef DRIVE_PROT_CONSTS_SVH
`define DRIVE_PROT_CONSTS_SVH
// Register offsets (16-bit word addresses)
`define OFS_LIM_MODE 16'h0019
`define OFS_LIM_LEVEL 16'h001a
`define OFS_OVC_MODE 16'h0307
`define OFS_OVL_RATE 16'h030c
`define OFS_STATUS 16'h0400
`define OFS_MASK 16'h0401
`define OFS_STATE 16'h0402
`define OFS_TRIP_CLR 16'h0403
// Reset values
`define RST_LIM_MODE 16'h0002
`define RST_LIM_LEVEL 16'h00b4
`define RST_OVC_MODE 16'h0001
`define RST_OVL_RATE 16'h7fff
// Field encodings and limits
`define LIM_MODE_OFF 16'h0000
`define LIM_MODE_CONST 16'h0001
`define LIM_MODE_ACCEL 16'h0002
`define LIM_LEVEL_MIN 16'h0014
`define LIM_LEVEL_MAX 16'h00c8
`define OVC_MODE_TRIP 16'h0000
`define OVC_MODE_BLANK 16'h0001
`define OVL_RATE_TIME 16'h0000
`define OVL_RATE_MAX 16'h2710
`define OVL_RATE_LIMIT 16'h7fff
`define LIM_RATE_DEF 16'h1388
// Status bit positions
`define ST_OC_TRIP 0
`define ST_GATE_BLANK 1
`define ST_LIM_ON 2
`define ST_OVL_ON 3
`define ST_BITS 4
// Timing: step tick period and derived cycle count
`define CLK_MHZ 100
`define STEP_TICK_US 10
`define STEP_TICK_CYC (`STEP_TICK_US * `CLK_MHZ)
`define STEP_SCALE (1000000 / `STEP_TICK_US)
`endif

//--- include/drive_prot_pkg.sv
// Types shared by the drive current protection block
`default_nettype none
package drive_prot_pkg;
   // Running state seen from the frequency ramp
   typedef enum logic [1:0] {RAMP_ACCEL, RAMP_CONST, RAMP_DECEL} ramp_state_t;
endpackage
`default_nettype wire

//--- hw/decel_stepper.sv
// Turns a rate in 0.01 Hz/s into single 0.01 Hz step pulses
`include "drive_prot_consts.svh"
`default_nettype none
module decel_stepper #(
   parameter int TICK_CYC = `STEP_TICK_CYC,
   parameter int SCALE = `STEP_SCALE
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [15:0] rate,
   output logic step
);
   // ****************************************
   // Tick divider and rate accumulator
   // ****************************************
   logic [15:0] tick_q; // Cycle counter within one tick
   logic [31:0] acc_q; // Fractional step accumulator
   wire tick_w = (tick_q == 16'(TICK_CYC - 1)); // One-cycle tick enable
   wire [31:0] sum_w = acc_q + {16'h0000, rate}; // Accumulated rate
   wire carry_w = tick_w && (sum_w >= 32'(SCALE)); // Whole step reached

   // Divider runs free so that steps keep a steady cadence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 16'h0000;
      end else if (tick_w) begin
         tick_q <= 16'h0000;
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   // Accumulator cleared while idle so each run starts fresh
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 32'h0000_0000;
         step <= 1'b0;
      end else begin
         step <= en && carry_w;
         if (!en) begin
            acc_q <= 32'h0000_0000;
         end else if (carry_w) begin
            acc_q <= sum_w - 32'(SCALE);
         end else if (tick_w) begin
            acc_q <= sum_w;
         end
      end
   end
endmodule // decel_stepper
`default_nettype wire

//--- hw/drive_current_protection.sv
// Current limiter, instantaneous over-current and overload prevention
`include "drive_prot_consts.svh"
`default_nettype none
module drive_current_protection #(
   parameter logic [15:0] LIM_RATE = `LIM_RATE_DEF
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata_q,
   input wire logic [15:0] freq_cmd,
   input wire logic [15:0] freq_target,
   input wire logic [15:0] current_pct,
   input wire logic ioc_detect,
   input wire logic heatsink_overheat_alarm,
   input wire logic inverter_overload_alarm,
   input wire logic decel_sel,
   input wire logic [15:0] decel_time_first,
   input wire logic [15:0] decel_time_second,
   output logic [15:0] freq_out_q,
   output logic gate_off_q,
   output logic oc_trip_q,
   output logic lim_active_q,
   output logic ovl_active_q,
   output logic ovl_ramp_req_q,
   output logic [15:0] ovl_decel_time_q,
   output logic irq_q
);
   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   logic rst_meta_q; // First reset release stage
   logic rst_n; // Released reset used everywhere
   logic [2:0] pin_meta_q; // First stage of pin inputs
   logic [2:0] pin_q; // Second stage, safe to read
   wire ioc_s = pin_q[0]; // Instantaneous over-current
   wire oh_s = pin_q[1]; // Heat sink overheat warning
   wire olu_s = pin_q[2]; // Inverter overload warning

   // Reset deasserts through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // Two-flop pin synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 3'h0;
         pin_q <= 3'h0;
      end else begin
         pin_meta_q <= {inverter_overload_alarm, heatsink_overheat_alarm, ioc_detect};
         pin_q <= pin_meta_q;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   logic [15:0] lim_mode_q; // current_limit_mode_sel
   logic [15:0] lim_level_q; // current_limit_level_pct
   logic [15:0] ovc_mode_q; // fast_overcurrent_mode_sel
   logic [15:0] ovl_rate_q; // overload_prevention_rate
   logic [`ST_BITS-1:0] status_q; // Sticky event bits
   logic [`ST_BITS-1:0] mask_q; // Interrupt enables
   logic [`ST_BITS-1:0] set_w; // Events this cycle
   // Write decode
   wire wr_mode_w = wr && (addr == `OFS_LIM_MODE) && (wdata <= `LIM_MODE_ACCEL);
   wire wr_level_w = wr && (addr == `OFS_LIM_LEVEL) && (wdata >= `LIM_LEVEL_MIN)
                     && (wdata <= `LIM_LEVEL_MAX);
   wire wr_ovc_w = wr && (addr == `OFS_OVC_MODE) && (wdata <= `OVC_MODE_BLANK);
   wire wr_rate_w = wr && (addr == `OFS_OVL_RATE) && (wdata <= `OVL_RATE_LIMIT);
   wire wr_mask_w = wr && (addr == `OFS_MASK);
   wire trip_clr_w = wr && (addr == `OFS_TRIP_CLR) && wdata[0];
   wire rd_status_w = rd && (addr == `OFS_STATUS);

   // Configuration registers; out-of-range writes are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lim_mode_q <= `RST_LIM_MODE;
         lim_level_q <= `RST_LIM_LEVEL;
         ovc_mode_q <= `RST_OVC_MODE;
         ovl_rate_q <= `RST_OVL_RATE;
         mask_q <= '0;
      end else begin
         if (wr_mode_w) lim_mode_q <= wdata;
         if (wr_level_w) lim_level_q <= wdata;
         if (wr_ovc_w) ovc_mode_q <= wdata;
         if (wr_rate_w) ovl_rate_q <= wdata;
         if (wr_mask_w) mask_q <= wdata[`ST_BITS-1:0];
      end
   end

   // ****************************************
   // Running state and limiter enable
   // ****************************************
   drive_prot_pkg::ramp_state_t ramp_q; // Ramp state seen last cycle
   drive_prot_pkg::ramp_state_t ramp_d; // Ramp state from compare
   assign ramp_d = (freq_cmd < freq_target) ? drive_prot_pkg::RAMP_ACCEL :
                   (freq_cmd > freq_target) ? drive_prot_pkg::RAMP_DECEL :
                   drive_prot_pkg::RAMP_CONST;
   // Enable per mode; never in deceleration
   wire lim_en_w = ((lim_mode_q == `LIM_MODE_CONST) && (ramp_q == drive_prot_pkg::RAMP_CONST))
                   || ((lim_mode_q == `LIM_MODE_ACCEL)
                   && (ramp_q != drive_prot_pkg::RAMP_DECEL));
   wire over_w = current_pct > lim_level_q;
   // Overload prevention on when alarm warns and not disabled
   wire ovl_on_w = (oh_s || olu_s) && (ovl_rate_q <= `OVL_RATE_MAX);
   wire ovl_time_w = ovl_rate_q == `OVL_RATE_TIME;
   wire blank_w = (ovc_mode_q == `OVC_MODE_BLANK) && ioc_s;

   // ****************************************
   // Frequency reduction steppers
   // ****************************************
   logic lim_step_w; // Limiter or recovery step
   logic ovl_step_w; // Overload prevention step
   logic [15:0] red_q; // Frequency reduction, 0.01 Hz
   logic [15:0] red_d; // Next reduction
   wire relax_w = !lim_active_q && !ovl_active_q && (red_q != 16'h0000); // Recovery

   decel_stepper u_lim_step (
      .clk(clk),
      .rst_n(rst_n),
      .en(lim_active_q || relax_w),
      .rate(LIM_RATE),
      .step(lim_step_w)
   );

   decel_stepper u_ovl_step (
      .clk(clk),
      .rst_n(rst_n),
      .en(ovl_active_q && !ovl_time_w),
      .rate(ovl_rate_q),
      .step(ovl_step_w)
   );

   // Grow while limiting or preventing, shrink while recovering
   wire grow_w = ((lim_step_w && lim_active_q) || ovl_step_w) && (red_q < freq_cmd);
   assign red_d = grow_w ? red_q + 16'h0001 :
                  (lim_step_w && relax_w) ? red_q - 16'h0001 :
                  (red_q > freq_cmd) ? freq_cmd : red_q;

   // Saturating subtraction of the reduction
   function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
      sat_sub = (a > b) ? a - b : 16'h0000;
   endfunction

   // Reduction, limiter and overload state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_q <= drive_prot_pkg::RAMP_CONST;
         red_q <= 16'h0000;
         lim_active_q <= 1'b0;
         ovl_active_q <= 1'b0;
      end else begin
         ramp_q <= ramp_d;
         red_q <= red_d;
         lim_active_q <= lim_en_w && over_w;
         ovl_active_q <= ovl_on_w;
      end
   end

   // Output frequency and overload ramp request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_out_q <= 16'h0000;
         ovl_ramp_req_q <= 1'b0;
         ovl_decel_time_q <= 16'h0000;
      end else begin
         freq_out_q <= sat_sub(freq_cmd, red_q);
         ovl_ramp_req_q <= ovl_on_w && ovl_time_w;
         ovl_decel_time_q <= decel_sel ? decel_time_second : decel_time_first;
      end
   end

   // ****************************************
   // Instantaneous over-current path
   // ****************************************
   wire trip_w = (ovc_mode_q == `OVC_MODE_TRIP) && ioc_s;

   // Trip latches until cleared; a new trip beats the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oc_trip_q <= 1'b0;
         gate_off_q <= 1'b0;
      end else begin
         oc_trip_q <= trip_w || (oc_trip_q && !trip_clr_w);
         gate_off_q <= trip_w || blank_w || (oc_trip_q && !trip_clr_w);
      end
   end

   // ****************************************
   // Status, interrupt and read data
   // ****************************************
   assign set_w[`ST_OC_TRIP] = trip_w && !oc_trip_q;
   assign set_w[`ST_GATE_BLANK] = blank_w;
   assign set_w[`ST_LIM_ON] = lim_en_w && over_w && !lim_active_q;
   assign set_w[`ST_OVL_ON] = ovl_on_w && !ovl_active_q;
   wire [15:0] state_w = {10'h000, ramp_q, ovl_active_q, lim_active_q, gate_off_q, oc_trip_q};
   wire [15:0] rdata_w = (addr == `OFS_LIM_MODE) ? lim_mode_q :
                         (addr == `OFS_LIM_LEVEL) ? lim_level_q :
                         (addr == `OFS_OVC_MODE) ? ovc_mode_q :
                         (addr == `OFS_OVL_RATE) ? ovl_rate_q :
                         (addr == `OFS_STATUS) ? {12'h000, status_q} :
                         (addr == `OFS_MASK) ? {12'h000, mask_q} :
                         (addr == `OFS_STATE) ? state_w : 16'h0000;

   // Sticky status cleared by read; set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= '0;
         irq_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         status_q <= rd_status_w ? set_w : (status_q | set_w);
         irq_q <= |(status_q & mask_q);
         rdata_q <= rd ? rdata_w : 16'h0000;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   lim_cond_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (lim_en_w && over_w) |=> lim_active_q)
      else $error("limiter did not engage on over-level current");

   lim_mode_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      $rose(lim_active_q) |-> ($past(lim_mode_q) != `LIM_MODE_OFF)
      && ($past(ramp_q) != drive_prot_pkg::RAMP_DECEL))
      else $error("limiter active in a disabled state");

   level_range_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (lim_level_q >= `LIM_LEVEL_MIN) && (lim_level_q <= `LIM_LEVEL_MAX))
      else $error("limiter level outside its range");

   trip_ioc_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      trip_w |=> oc_trip_q && gate_off_q)
      else $error("no trip on instantaneous over-current");

   blank_only_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (blank_w && !oc_trip_q) |=> gate_off_q && !oc_trip_q)
      else $error("gate blanking missing or tripped");

   ovl_follow_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      ((oh_s || olu_s) && (ovl_rate_q <= `OVL_RATE_MAX)) [*2] |-> ovl_active_q)
      else $error("overload prevention not active on alarm");

   ovl_time_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (ovl_on_w && ovl_time_w) |=> ovl_ramp_req_q
      && (ovl_decel_time_q == ($past(decel_sel) ? $past(decel_time_second)
      : $past(decel_time_first))))
      else $error("wrong deceleration time for overload prevention");

   ovl_step_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (ovl_step_w && (red_q < freq_cmd)) |=> red_q == $past(red_q) + 16'h0001)
      else $error("overload step did not lower frequency");

   ovl_off_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (ovl_rate_q > `OVL_RATE_MAX) |=> !ovl_active_q && !ovl_ramp_req_q)
      else $error("overload prevention active while disabled");

   ramp_cmp_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (freq_cmd > freq_target) |=> ramp_q == drive_prot_pkg::RAMP_DECEL)
      else $error("running state not taken from ramp compare");

   lim_off_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      (lim_mode_q == `LIM_MODE_OFF) |=> !lim_active_q)
      else $error("limiter active with mode off");

   freq_cap_a:
   assert property (@(posedge clk) disable iff (!rst_n)
      freq_out_q <= $past(freq_cmd))
      else $error("output frequency above command");
endmodule // drive_current_protection
`default_nettype wire

//--- verif/power_stage_model.sv
// Behavioural power stage, gate drive and current sensing
`default_nettype none
module power_stage_model (
   input wire logic clk,
   input wire logic gate_off,
   input wire logic [15:0] load_pct,
   input wire logic ioc_req,
   input wire logic heat_req,
   input wire logic olu_req,
   output logic [15:0] current_pct,
   output logic ioc_detect,
   output logic heatsink_overheat_alarm,
   output logic inverter_overload_alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   // Sensed current collapses while the gates are blanked
   always @(posedge clk) begin
      current_pct <= gate_off ? 16'h0000 : load_pct;
      ioc_detect <= ioc_req;
      heatsink_overheat_alarm <= heat_req;
      inverter_overload_alarm <= olu_req;
   end
endmodule // power_stage_model
`default_nettype wire

//--- verif/drive_current_protection_tb.sv
// Self-checking bench for the drive current protection block
`include "drive_prot_consts.svh"
`default_nettype none
module drive_current_protection_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // Signals
   // ********************
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] freq_cmd = 16'h1000;
   logic [15:0] freq_target = 16'h1000;
   logic decel_sel = 1'b0;
   logic [15:0] decel_time_first = 16'h0064;
   logic [15:0] decel_time_second = 16'h00c8;
   logic [15:0] load_pct = 16'h0000;
   logic ioc_req = 1'b0;
   logic heat_req = 1'b0;
   logic olu_req = 1'b0;
   logic [15:0] rdata_q, current_pct, freq_out_q, ovl_decel_time_q, got;
   logic ioc_detect, heat_al, olu_al, gate_off_q, oc_trip_q, lim_active_q;
   logic ovl_active_q, ovl_ramp_req_q, irq_q;
   logic [31:0] seed = 32'h3116d5fb;
   int bad_count = 0;
   int comparisons = 0;
   // ********************
   // Design and far side
   // ********************
   drive_current_protection #(.LIM_RATE(16'hffff)) uut (.clk(clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .freq_cmd(freq_cmd),
      .freq_target(freq_target), .current_pct(current_pct), .ioc_detect(ioc_detect),
      .heatsink_overheat_alarm(heat_al), .inverter_overload_alarm(olu_al),
      .decel_sel(decel_sel), .decel_time_first(decel_time_first),
      .decel_time_second(decel_time_second), .freq_out_q(freq_out_q), .gate_off_q(gate_off_q),
      .oc_trip_q(oc_trip_q), .lim_active_q(lim_active_q), .ovl_active_q(ovl_active_q),
      .ovl_ramp_req_q(ovl_ramp_req_q), .ovl_decel_time_q(ovl_decel_time_q), .irq_q(irq_q));
   power_stage_model stage (.clk(clk), .gate_off(gate_off_q), .load_pct(load_pct),
      .ioc_req(ioc_req), .heat_req(heat_req), .olu_req(olu_req), .current_pct(current_pct),
      .ioc_detect(ioc_detect), .heatsink_overheat_alarm(heat_al),
      .inverter_overload_alarm(olu_al));
   // 100 MHz clock
   always #5 clk = ~clk;
   // ********************
   // Helpers
   // ********************
   // Next pseudo-random word
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Limiter enable by mode and ramp state
   function automatic logic lim_exp(input int m, input int s);
      return (m == 2 && s < 2) || (m == 1 && s == 1);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic seen);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", what, exp, seen);
      end
   endtask
   // One-cycle write strobe
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One-cycle read strobe, data taken in the following cycle
   task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata_q;
   endtask
   // Ramp state from command versus target
   task automatic set_state(input int s);
      @(posedge clk);
      freq_cmd <= (s == 0) ? 16'h0800 : (s == 1) ? 16'h1000 : 16'h1800;
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog against a hang; the tests need about 13.4k cycles
   initial begin
      #300us;
      bad_count++;
      give_verdict();
   end
   // ********************
   // Tests
   // ********************
   initial begin
      static logic [15:0] lv_in [4] = '{16'h0014, 16'h0013, 16'h00c8, 16'h00c9};
      static logic [15:0] lv_ex [4] = '{16'h0014, 16'h0014, 16'h00c8, 16'h00c8};
      tick(6);
      resetn <= 1'b1;
      tick(3);
      rd_reg(`OFS_LIM_MODE, got);
      chk16("mode reset", `RST_LIM_MODE, got);
      rd_reg(`OFS_LIM_LEVEL, got);
      chk16("level reset", `RST_LIM_LEVEL, got);
      rd_reg(`OFS_OVC_MODE, got);
      chk16("fast mode reset", `RST_OVC_MODE, got);
      rd_reg(`OFS_OVL_RATE, got);
      chk16("rate reset", `RST_OVL_RATE, got);
      rd_reg(16'h0123, got);
      chk16("unmapped read", 16'h0000, got);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`OFS_LIM_LEVEL, lv_in[i]);
         rd_reg(`OFS_LIM_LEVEL, got);
         chk16("level bound", lv_ex[i], got);
      end
      wr_reg(`OFS_LIM_MODE, 16'h0003);
      rd_reg(`OFS_LIM_MODE, got);
      chk16("mode refused", `RST_LIM_MODE, got);
      repeat (8) begin
         seed = lfsr(seed);
         wr_reg(`OFS_LIM_LEVEL, 16'd20 + 16'(seed % 181));
         rd_reg(`OFS_LIM_LEVEL, got);
         chk16("level random", 16'd20 + 16'(seed % 181), got);
      end
      $display("test registers done");
      // Limiter over every mode and ramp state; fast limiting kept on
      wr_reg(`OFS_LIM_LEVEL, 16'd100);
      load_pct <= 16'd150;
      for (int m = 0; m < 3; m++) begin
         for (int s = 0; s < 3; s++) begin
            wr_reg(`OFS_LIM_MODE, 16'(m));
            set_state(s);
            tick(8);
            chk1("limiter engaged", lim_exp(m, s), lim_active_q);
            rd_reg(`OFS_STATE, got);
            chk16("ramp state", 16'(s), {14'h0000, got[5:4]});
         end
      end
      set_state(1);
      tick(3000);
      chk1("frequency lowered", 1'b1, freq_out_q < freq_cmd);
      load_pct <= 16'd100;
      tick(8);
      chk1("limiter at level", 1'b0, lim_active_q);
      load_pct <= 16'd0;
      $display("test limiter done");
      // Trip mode with interrupt
      wr_reg(`OFS_OVC_MODE, `OVC_MODE_TRIP);
      wr_reg(`OFS_MASK, 16'h0001);
      ioc_req <= 1'b1;
      tick(4);
      ioc_req <= 1'b0;
      tick(4);
      chk1("trip", 1'b1, oc_trip_q);
      chk1("trip gates", 1'b1, gate_off_q);
      chk1("irq set", 1'b1, irq_q);
      rd_reg(`OFS_STATUS, got);
      chk1("status trip", 1'b1, got[`ST_OC_TRIP]);
      tick(3);
      chk1("irq cleared", 1'b0, irq_q);
      wr_reg(`OFS_TRIP_CLR, 16'h0001);
      tick(3);
      chk1("trip cleared", 1'b0, oc_trip_q);
      // Blanking mode
      wr_reg(`OFS_OVC_MODE, `OVC_MODE_BLANK);
      ioc_req <= 1'b1;
      tick(6);
      chk1("blank gates", 1'b1, gate_off_q);
      chk1("blank no trip", 1'b0, oc_trip_q);
      ioc_req <= 1'b0;
      tick(6);
      chk1("gates back", 1'b0, gate_off_q);
      rd_reg(`OFS_STATUS, got);
      chk1("status blank", 1'b1, got[`ST_GATE_BLANK]);
      tick(1);
      $display("test over-current done");
      // Overload prevention settings
      heat_req <= 1'b1;
      tick(6);
      chk1("disabled default", 1'b0, ovl_active_q);
      wr_reg(`OFS_OVL_RATE, `OVL_RATE_TIME);
      tick(6);
      chk1("heat engaged", 1'b1, ovl_active_q);
      chk1("ramp request", 1'b1, ovl_ramp_req_q);
      for (int s = 0; s < 2; s++) begin
         decel_sel <= s[0];
         tick(3);
         chk16("decel time", s ? decel_time_second : decel_time_first, ovl_decel_time_q);
      end
      heat_req <= 1'b0;
      olu_req <= 1'b1;
      wr_reg(`OFS_OVL_RATE, `OVL_RATE_MAX);
      tick(6);
      chk1("rate engaged", 1'b1, ovl_active_q);
      chk1("own rate", 1'b0, ovl_ramp_req_q);
      rd_reg(`OFS_STATUS, got);
      chk1("status overload", 1'b1, got[`ST_OVL_ON]);
      // 100.00 Hz/s over about 101 us gives exactly one 0.01 Hz step
      got = freq_out_q;
      tick(10100);
      chk16("overload step", got - 16'h0001, freq_out_q);
      wr_reg(`OFS_OVL_RATE, 16'h2711);
      tick(6);
      chk1("above rate", 1'b0, ovl_active_q);
      olu_req <= 1'b0;
      $display("test overload done");
      give_verdict();
   end
endmodule // drive_current_protection_tb
`default_nettype wire
